/* src/logger_alarm_mission_control.sv */
// alarm thresholds, control registers, alarm flags and mission sequencing of the logger
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: during a humidity mission always log the humidity upper byte (sensor bits 11..4)
// R2: log the humidity lower byte only when wide humidity format is selected
// R3: humidity wide format bit in mission configuration picks 8 or 16 bit logging
// R4: humidity low and high threshold bytes sit at two fixed addresses
// R5: humidity alarms compare only the upper byte of the reading
// R6: humidity thresholds apply to the raw uncorrected reading
// R7: two temperature threshold bytes; temperature flags shown in alarm status register
// R8: temperature enables in bits 1 and 0; upper six bits read 0
// R9: humidity enables in bits 1 and 0; upper six bits read 1
// R10: while a mission runs, control and configuration registers are read only
// R11: enabled temperature high alarm sets flag on conversion at or above threshold
// R12: enabled temperature low alarm sets flag on conversion at or below threshold
// R13: enabled humidity high alarm sets flag on reading at or above threshold
// R14: enabled humidity low alarm sets flag on reading at or below threshold
// R15: clock control bit 1 picks seconds (1) or minutes (0); bits 2..7 read 0
// R16: clock control bit 0 runs the oscillator; 0 stops it for retention
// R17: forced conversion or mission start sets the oscillator enable
// R18: start on temperature alarm waits converting, logs only after an alarm
// R19: the triggering sample is logged but does not count as a sample
// R20: start on temperature alarm only works with temperature logging enabled
// R21: wrap enable overwrites at full; otherwise logging stops at full
// R22: temperature alarms compare only the upper byte of the conversion
// R23: at full without wrap, stop conversions and logging; mission stays active
// R24: clear memory command clears all alarm flags together
// R25: alarm flags are sticky; comparisons are unsigned bytes
module logger_alarm_mission_control (
    input wire logic CLOCK_I,
    input wire logic RSTN_I,
    input wire logic [9:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [7:0] REG_RDATA_O,
    input wire logic START_MISSION_I,
    input wire logic STOP_MISSION_I,
    input wire logic FORCED_CONV_I,
    input wire logic CLEAR_MEMORY_I,
    input wire logic SAMPLE_TICK_I,
    input wire logic TEMP_VALID_I,
    input wire logic [15:0] TEMP_RESULT_I,
    input wire logic HUM_VALID_I,
    input wire logic [15:0] HUM_RESULT_I,
    input wire logic LOG_FULL_I,
    output logic CONV_REQ_O,
    output logic CONV_TEMP_ONLY_O,
    output logic LOG_WR_O,
    output logic LOG_HUM_O,
    output logic [7:0] LOG_DATA_O,
    output logic SAMPLE_INC_O,
    output logic MISSION_ACTIVE_O,
    output logic WAITING_ALARM_O,
    output logic LOG_HALTED_O,
    output logic OSC_ENABLE_O,
    output logic SECONDS_UNIT_O,
    output logic [3:0] ALARM_FLAGS_O
);
    typedef enum logic [1:0] {LOG_IDLE, LOG_TEMP_LOW, LOG_HUM_LOW} log_state_type;

    logic [7:0] temp_low_thr_q, temp_low_thr_d;
    logic [7:0] temp_high_thr_q, temp_high_thr_d;
    logic [7:0] hum_low_thr_q, hum_low_thr_d;
    logic [7:0] hum_high_thr_q, hum_high_thr_d;
    logic [15:0] hum_result_q, hum_result_d;
    logic [1:0] temp_en_q, temp_en_d;
    logic [1:0] hum_en_q, hum_en_d;
    logic [1:0] clk_ctl_q, clk_ctl_d;
    logic [5:0] cfg_q, cfg_d;
    logic [3:0] flags_q, flags_d;
    logic active_q, active_d;
    logic waiting_q, waiting_d;
    logic halted_q, halted_d;
    logic conv_req_q, conv_req_d;
    logic inc_q, inc_d;
    log_state_type log_state_q, log_state_d;
    logic log_wr_q, log_wr_d;
    logic log_hum_q, log_hum_d;
    logic [7:0] log_data_q, log_data_d;
    logic [7:0] pend_q, pend_d;
    logic [7:0] rdata_q, rdata_d;

    logic [7:0] temp_msb;
    logic [7:0] hum_msb;
    logic temp_hi_hit, temp_lo_hit, hum_hi_hit, hum_lo_hit;
    logic start_ok;
    logic cfg_write_ok;
    logic temp_trigger;
    logic temp_fire;
    logic hum_fire;

    // shared compare and qualify terms
    assign temp_msb = TEMP_RESULT_I[15:8]; // R22
    assign hum_msb = HUM_RESULT_I[15:8]; // R5 R6
    assign temp_hi_hit = temp_msb >= temp_high_thr_q; // R25
    assign temp_lo_hit = temp_msb <= temp_low_thr_q;
    assign hum_hi_hit = hum_msb >= hum_high_thr_q;
    assign hum_lo_hit = hum_msb <= hum_low_thr_q;
    assign start_ok = START_MISSION_I && !active_q
        && (cfg_q[logger_pkg::CFG_TEMP_LOG_BIT] || cfg_q[logger_pkg::CFG_HUM_LOG_BIT]);
    assign cfg_write_ok = REG_WR_I && !active_q; // R10
    assign temp_trigger = active_q && waiting_q && TEMP_VALID_I
        && (temp_hi_hit || temp_lo_hit); // R18
    assign temp_fire = active_q && !halted_q && TEMP_VALID_I && log_state_q == LOG_IDLE
        && cfg_q[logger_pkg::CFG_TEMP_LOG_BIT] && (!waiting_q || temp_trigger);
    assign hum_fire = active_q && !halted_q && !waiting_q && HUM_VALID_I && !TEMP_VALID_I
        && log_state_q == LOG_IDLE && cfg_q[logger_pkg::CFG_HUM_LOG_BIT]; // R1

    // register file next values
    always_comb begin
        temp_low_thr_d = temp_low_thr_q;
        temp_high_thr_d = temp_high_thr_q;
        hum_low_thr_d = hum_low_thr_q;
        hum_high_thr_d = hum_high_thr_q;
        temp_en_d = temp_en_q;
        hum_en_d = hum_en_q;
        clk_ctl_d = clk_ctl_q;
        cfg_d = cfg_q;
        hum_result_d = HUM_VALID_I ? HUM_RESULT_I : hum_result_q;
        if (REG_WR_I) begin
            case (REG_ADDR_I)
                logger_pkg::OFS_TEMP_LOW_THR: temp_low_thr_d = REG_WDATA_I; // R7
                logger_pkg::OFS_TEMP_HIGH_THR: temp_high_thr_d = REG_WDATA_I;
                logger_pkg::OFS_HUM_LOW_THR: hum_low_thr_d = REG_WDATA_I; // R4
                logger_pkg::OFS_HUM_HIGH_THR: hum_high_thr_d = REG_WDATA_I;
                default: ;
            endcase
        end
        if (cfg_write_ok) begin
            case (REG_ADDR_I)
                logger_pkg::OFS_TEMP_ALARM_EN: temp_en_d = REG_WDATA_I[1:0]; // R8
                logger_pkg::OFS_HUM_ALARM_EN: hum_en_d = REG_WDATA_I[1:0]; // R9
                logger_pkg::OFS_CLOCK_CONTROL: clk_ctl_d = REG_WDATA_I[1:0]; // R15 R16
                logger_pkg::OFS_MISSION_CONFIG: cfg_d = REG_WDATA_I[5:0]; // R3
                default: ;
            endcase
        end
        if (FORCED_CONV_I || start_ok) begin
            clk_ctl_d[logger_pkg::CLK_OSC_BIT] = 1'b1; // R17
        end
    end

    // register file storage
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            temp_low_thr_q <= logger_pkg::THR_RESET;
            temp_high_thr_q <= logger_pkg::THR_RESET;
            hum_low_thr_q <= logger_pkg::THR_RESET;
            hum_high_thr_q <= logger_pkg::THR_RESET;
            hum_result_q <= logger_pkg::HUM_RESULT_RESET;
            temp_en_q <= logger_pkg::CTL_RESET[1:0];
            hum_en_q <= logger_pkg::CTL_RESET[1:0];
            clk_ctl_q <= logger_pkg::CTL_RESET[1:0];
            cfg_q <= logger_pkg::CTL_RESET[5:0];
        end else begin
            temp_low_thr_q <= temp_low_thr_d;
            temp_high_thr_q <= temp_high_thr_d;
            hum_low_thr_q <= hum_low_thr_d;
            hum_high_thr_q <= hum_high_thr_d;
            hum_result_q <= hum_result_d;
            temp_en_q <= temp_en_d;
            hum_en_q <= hum_en_d;
            clk_ctl_q <= clk_ctl_d;
            cfg_q <= cfg_d;
        end
    end

    // mission state and alarm flags next values
    always_comb begin
        active_d = active_q;
        waiting_d = waiting_q;
        halted_d = halted_q;
        flags_d = flags_q;
        conv_req_d = 1'b0;
        inc_d = 1'b0;
        if (CLEAR_MEMORY_I) begin
            flags_d = logger_pkg::FLAGS_RESET; // R24
        end
        if (active_q && TEMP_VALID_I) begin
            if (temp_en_q[logger_pkg::EN_HIGH_BIT] && temp_hi_hit) begin
                flags_d[logger_pkg::FLAG_TEMP_HIGH] = 1'b1; // R11
            end
            if (temp_en_q[logger_pkg::EN_LOW_BIT] && temp_lo_hit) begin
                flags_d[logger_pkg::FLAG_TEMP_LOW] = 1'b1; // R12
            end
        end
        if (active_q && HUM_VALID_I && !waiting_q) begin
            if (hum_en_q[logger_pkg::EN_HIGH_BIT] && hum_hi_hit) begin
                flags_d[logger_pkg::FLAG_HUM_HIGH] = 1'b1; // R13
            end
            if (hum_en_q[logger_pkg::EN_LOW_BIT] && hum_lo_hit) begin
                flags_d[logger_pkg::FLAG_HUM_LOW] = 1'b1; // R14
            end
        end
        if (temp_trigger) begin
            waiting_d = 1'b0;
        end
        if (active_q && LOG_FULL_I && !cfg_q[logger_pkg::CFG_WRAP_BIT]) begin
            halted_d = 1'b1; // R21 R23
        end
        if (active_q && !halted_q && SAMPLE_TICK_I) begin
            conv_req_d = 1'b1; // R23
        end
        // one count per sample, not per record; the triggering sample is not counted
        if (temp_fire && !temp_trigger) begin
            inc_d = 1'b1; // R19
        end else if (hum_fire && !cfg_q[logger_pkg::CFG_TEMP_LOG_BIT]) begin
            inc_d = 1'b1;
        end
        if (start_ok) begin
            active_d = 1'b1;
            halted_d = 1'b0;
            waiting_d = cfg_q[logger_pkg::CFG_START_ALARM_BIT]
                && cfg_q[logger_pkg::CFG_TEMP_LOG_BIT]; // R18 R20
        end else if (STOP_MISSION_I) begin
            active_d = 1'b0;
        end
    end

    // mission state and alarm flags storage
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            active_q <= 1'b0;
            waiting_q <= 1'b0;
            halted_q <= 1'b0;
            flags_q <= logger_pkg::FLAGS_RESET;
            conv_req_q <= 1'b0;
            inc_q <= 1'b0;
        end else begin
            active_q <= active_d;
            waiting_q <= waiting_d;
            halted_q <= halted_d;
            flags_q <= flags_d;
            conv_req_q <= conv_req_d;
            inc_q <= inc_d;
        end
    end

    // log byte sequencer: upper byte first, lower byte next cycle if wide, except for the temperature alarm trigger sample
    always_comb begin
        log_state_d = LOG_IDLE;
        log_wr_d = 1'b0;
        log_hum_d = log_hum_q;
        log_data_d = log_data_q;
        pend_d = pend_q;
        case (log_state_q)
            LOG_IDLE: begin
                if (temp_fire) begin
                    log_wr_d = 1'b1;
                    log_hum_d = 1'b0;
                    log_data_d = TEMP_RESULT_I[15:8];
                    pend_d = TEMP_RESULT_I[7:0];
                    if (cfg_q[logger_pkg::CFG_TEMP_WIDE_BIT] && !waiting_q) begin
                        log_state_d = LOG_TEMP_LOW;
                    end
                end else if (hum_fire) begin
                    log_wr_d = 1'b1;
                    log_hum_d = 1'b1;
                    log_data_d = HUM_RESULT_I[15:8]; // R1
                    pend_d = HUM_RESULT_I[7:0];
                    if (cfg_q[logger_pkg::CFG_HUM_WIDE_BIT]) begin
                        log_state_d = LOG_HUM_LOW; // R2 R3
                    end
                end
            end
            LOG_TEMP_LOW, LOG_HUM_LOW: begin
                log_wr_d = 1'b1;
                log_data_d = pend_q; // R2
            end
            default: log_state_d = LOG_IDLE;
        endcase
    end

    // log sequencer storage
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            log_state_q <= LOG_IDLE;
            log_wr_q <= 1'b0;
            log_hum_q <= 1'b0;
            log_data_q <= 8'h00;
            pend_q <= 8'h00;
        end else begin
            log_state_q <= log_state_d;
            log_wr_q <= log_wr_d;
            log_hum_q <= log_hum_d;
            log_data_q <= log_data_d;
            pend_q <= pend_d;
        end
    end

    // read data mux, registered, held between reads
    always_comb begin
        rdata_d = rdata_q;
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                logger_pkg::OFS_TEMP_LOW_THR: rdata_d = temp_low_thr_q;
                logger_pkg::OFS_TEMP_HIGH_THR: rdata_d = temp_high_thr_q;
                logger_pkg::OFS_HUM_LOW_THR: rdata_d = hum_low_thr_q;
                logger_pkg::OFS_HUM_HIGH_THR: rdata_d = hum_high_thr_q;
                logger_pkg::OFS_HUM_RESULT_LOW: rdata_d = hum_result_q[7:0];
                logger_pkg::OFS_HUM_RESULT_HIGH: rdata_d = hum_result_q[15:8];
                logger_pkg::OFS_TEMP_ALARM_EN: rdata_d = logger_pkg::TEMP_EN_FIXED
                    | ({6'h00, temp_en_q} & logger_pkg::EN_WRITE_MASK); // R8
                logger_pkg::OFS_HUM_ALARM_EN: rdata_d = logger_pkg::HUM_EN_FIXED
                    | ({6'h00, hum_en_q} & logger_pkg::EN_WRITE_MASK); // R9
                logger_pkg::OFS_CLOCK_CONTROL: rdata_d = logger_pkg::CLK_FIXED
                    | ({6'h00, clk_ctl_q} & logger_pkg::CLK_WRITE_MASK); // R15
                logger_pkg::OFS_MISSION_CONFIG: rdata_d = logger_pkg::CFG_FIXED
                    | ({2'h0, cfg_q} & logger_pkg::CFG_WRITE_MASK);
                logger_pkg::OFS_ALARM_STATUS: rdata_d = logger_pkg::ALARM_FIXED
                    | {4'h0, flags_q}; // R7
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // read data storage
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // outputs straight from flops
    assign REG_RDATA_O = rdata_q;
    assign CONV_REQ_O = conv_req_q;
    assign CONV_TEMP_ONLY_O = waiting_q; // R18
    assign LOG_WR_O = log_wr_q;
    assign LOG_HUM_O = log_hum_q;
    assign LOG_DATA_O = log_data_q;
    assign SAMPLE_INC_O = inc_q;
    assign MISSION_ACTIVE_O = active_q;
    assign WAITING_ALARM_O = waiting_q;
    assign LOG_HALTED_O = halted_q;
    assign OSC_ENABLE_O = clk_ctl_q[logger_pkg::CLK_OSC_BIT]; // R16
    assign SECONDS_UNIT_O = clk_ctl_q[logger_pkg::CLK_SECONDS_BIT]; // R15
    assign ALARM_FLAGS_O = flags_q;

    // checks
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RSTN_I);

    a_cfg_write_lock: assert property ( // R10
        active_q && REG_WR_I && REG_ADDR_I == logger_pkg::OFS_MISSION_CONFIG
        |=> $stable(cfg_q))
        else $error("configuration changed during mission");
    a_temp_high_set: assert property ( // R11
        active_q && TEMP_VALID_I && temp_en_q[1] && TEMP_RESULT_I[15:8] >= temp_high_thr_q
        |=> ALARM_FLAGS_O[1])
        else $error("temperature high flag not set");
    a_temp_high_cause: assert property ( // R11
        $rose(ALARM_FLAGS_O[1]) |-> $past(temp_en_q[1]) && $past(TEMP_VALID_I))
        else $error("temperature high flag set without enable");
    a_temp_low_set: assert property ( // R12
        active_q && TEMP_VALID_I && temp_en_q[0] && TEMP_RESULT_I[15:8] <= temp_low_thr_q
        |=> ALARM_FLAGS_O[0])
        else $error("temperature low flag not set");
    a_hum_high_set: assert property ( // R13
        active_q && !waiting_q && HUM_VALID_I && hum_en_q[1]
        && HUM_RESULT_I[15:8] >= hum_high_thr_q |=> ALARM_FLAGS_O[3])
        else $error("humidity high flag not set");
    a_hum_low_set: assert property ( // R14
        active_q && !waiting_q && HUM_VALID_I && hum_en_q[0]
        && HUM_RESULT_I[15:8] <= hum_low_thr_q |=> ALARM_FLAGS_O[2])
        else $error("humidity low flag not set");
    a_flag_sticky: assert property ( // R25
        !CLEAR_MEMORY_I |=> (ALARM_FLAGS_O & $past(ALARM_FLAGS_O)) == $past(ALARM_FLAGS_O))
        else $error("alarm flag dropped without clear");
    a_flags_clear: assert property ( // R24
        CLEAR_MEMORY_I && !TEMP_VALID_I && !HUM_VALID_I |=> ALARM_FLAGS_O == 4'h0)
        else $error("clear memory left a flag set");
    a_osc_autostart: assert property ( // R17
        FORCED_CONV_I |=> OSC_ENABLE_O)
        else $error("oscillator not enabled by command");
    a_hum_upper_log: assert property ( // R1
        hum_fire |=> LOG_WR_O && LOG_HUM_O && LOG_DATA_O == $past(HUM_RESULT_I[15:8]))
        else $error("humidity upper byte not logged");
    a_hum_lower_log: assert property ( // R2
        hum_fire |=> ##1 (LOG_WR_O == cfg_q[3]))
        else $error("humidity lower byte logged in wrong format");
    a_halt_no_conv: assert property ( // R23
        halted_q && MISSION_ACTIVE_O
        |=> !CONV_REQ_O && (MISSION_ACTIVE_O || $past(STOP_MISSION_I)))
        else $error("conversion requested after log full");
    a_trigger_no_count: assert property ( // R19
        temp_trigger |=> !SAMPLE_INC_O && LOG_WR_O && !WAITING_ALARM_O)
        else $error("trigger sample counted or not logged");
endmodule

`default_nettype wire

/* src/logger_pkg.sv */
// constants for the logger alarm and mission control block
package logger_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // register offsets
    localparam logic [9:0] OFS_TEMP_LOW_THR = 10'h208;
    localparam logic [9:0] OFS_TEMP_HIGH_THR = 10'h209;
    localparam logic [9:0] OFS_HUM_LOW_THR = 10'h20A;
    localparam logic [9:0] OFS_HUM_HIGH_THR = 10'h20B;
    localparam logic [9:0] OFS_HUM_RESULT_LOW = 10'h20E;
    localparam logic [9:0] OFS_HUM_RESULT_HIGH = 10'h20F;
    localparam logic [9:0] OFS_TEMP_ALARM_EN = 10'h210;
    localparam logic [9:0] OFS_HUM_ALARM_EN = 10'h211;
    localparam logic [9:0] OFS_CLOCK_CONTROL = 10'h212;
    localparam logic [9:0] OFS_MISSION_CONFIG = 10'h213;
    localparam logic [9:0] OFS_ALARM_STATUS = 10'h214;

    // alarm enable register fields
    localparam int EN_LOW_BIT = 0;
    localparam int EN_HIGH_BIT = 1;
    localparam logic [7:0] EN_WRITE_MASK = 8'h03;
    localparam logic [7:0] TEMP_EN_FIXED = 8'h00;
    localparam logic [7:0] HUM_EN_FIXED = 8'hFC;

    // clock control fields
    localparam int CLK_OSC_BIT = 0;
    localparam int CLK_SECONDS_BIT = 1;
    localparam logic [7:0] CLK_WRITE_MASK = 8'h03;
    localparam logic [7:0] CLK_FIXED = 8'h00;

    // mission configuration fields
    localparam int CFG_TEMP_LOG_BIT = 0;
    localparam int CFG_HUM_LOG_BIT = 1;
    localparam int CFG_TEMP_WIDE_BIT = 2;
    localparam int CFG_HUM_WIDE_BIT = 3;
    localparam int CFG_WRAP_BIT = 4;
    localparam int CFG_START_ALARM_BIT = 5;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;
    localparam logic [7:0] CFG_FIXED = 8'hC0;

    // alarm status flag positions
    localparam int FLAG_TEMP_LOW = 0;
    localparam int FLAG_TEMP_HIGH = 1;
    localparam int FLAG_HUM_LOW = 2;
    localparam int FLAG_HUM_HIGH = 3;
    localparam logic [7:0] ALARM_FIXED = 8'h70;

    // reset values
    localparam logic [7:0] THR_RESET = 8'h00;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [15:0] HUM_RESULT_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
endpackage

/* verif/host_bus_model.sv */
// host side model of the register byte port of the logger control block
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [9:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // idle bus at time zero
    initial begin
        addr_o = 10'h3FF;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one write strobe, then scrambled lines so stale values never look valid
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
    endtask
    // read strobe; data taken just after the edge that samples it
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

/* verif/tb_logger_alarm_mission_control.sv */
// self-checking bench of the logger alarm and mission control block
`timescale 1ns/1ps
`default_nettype none
module tb_logger_alarm_mission_control;
    logic clk, rstn, wr, rd, start, stop, fconv, clr, tick, tval, hval, full;
    logic conv_req, conv_t, log_wr, log_hum, s_inc, active, waiting, halted, osc, secs;
    logic [9:0] addr;
    logic [7:0] wdata, rdata, log_data;
    logic [15:0] tres, hres;
    logic [3:0] flags;
    int errors = 0;
    int n_checks = 0;
    logger_alarm_mission_control i_dut (.CLOCK_I(clk), .RSTN_I(rstn), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .START_MISSION_I(start), .STOP_MISSION_I(stop), .FORCED_CONV_I(fconv),
        .CLEAR_MEMORY_I(clr), .SAMPLE_TICK_I(tick), .TEMP_VALID_I(tval), .TEMP_RESULT_I(tres),
        .HUM_VALID_I(hval), .HUM_RESULT_I(hres), .LOG_FULL_I(full), .CONV_REQ_O(conv_req),
        .CONV_TEMP_ONLY_O(conv_t), .LOG_WR_O(log_wr), .LOG_HUM_O(log_hum), .LOG_DATA_O(log_data),
        .SAMPLE_INC_O(s_inc), .MISSION_ACTIVE_O(active), .WAITING_ALARM_O(waiting),
        .LOG_HALTED_O(halted), .OSC_ENABLE_O(osc), .SECONDS_UNIT_O(secs), .ALARM_FLAGS_O(flags));
    host_bus_model i_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
        .wr_o(wr), .rd_o(rd));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // byte and bit compares
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic bchk(input string n, input logic e, input logic g);
        chk(n, {7'h00, e}, {7'h00, g});
    endtask
    task automatic rchk(input logic [9:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), e, d);
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // one-cycle command pulse {start, stop, forced, clear, tick}
    task automatic fire(input logic [4:0] m);
        @(posedge clk);
        {start, stop, fconv, clr, tick} <= m;
        @(posedge clk);
        {start, stop, fconv, clr, tick} <= 5'h00;
        #1;
    endtask
    // one result pulse, humidity when h is set; returns in the answer cycle
    task automatic smp(input logic h, input logic [15:0] v);
        @(posedge clk);
        if (h) begin
            hval <= 1'b1;
            hres <= v;
        end else begin
            tval <= 1'b1;
            tres <= v;
        end
        @(posedge clk);
        hval <= 1'b0;
        tval <= 1'b0;
        hres <= ~v;
        tres <= ~v;
        #1;
    endtask
    // reset values, fixed bits, clock control and thresholds
    task automatic t_regs;
        logic [7:0] thr [4] = '{8'h20, 8'h85, 8'h40, 8'hB5};
        rchk(10'h210, 8'h00);
        rchk(10'h211, 8'hFC);
        rchk(10'h212, 8'h00);
        rchk(10'h213, 8'hC0);
        rchk(10'h214, 8'h70);
        rchk(10'h300, 8'h00);
        i_host.wr(10'h210, 8'hFF);
        rchk(10'h210, 8'h03);
        i_host.wr(10'h211, 8'h00);
        rchk(10'h211, 8'hFC);
        i_host.wr(10'h212, 8'hFE);
        rchk(10'h212, 8'h02);
        bchk("secs", 1'b1, secs);
        bchk("osc", 1'b0, osc);
        fire(5'h04);
        bchk("osc", 1'b1, osc);
        i_host.wr(10'h212, 8'h02);
        bchk("osc", 1'b0, osc);
        i_host.wr(10'h20F, 8'h55);
        rchk(10'h20F, 8'h00);
        for (int i = 0; i < 4; i++) begin
            i_host.wr(10'h208 + 10'(i), thr[i]);
            rchk(10'h208 + 10'(i), thr[i]);
        end
    endtask
    // humidity missions, narrow then wide, sticky flags and clear
    task automatic t_hum;
        i_host.wr(10'h211, 8'h03);
        i_host.wr(10'h213, 8'h02);
        fire(5'h10);
        bchk("active", 1'b1, active);
        bchk("osc", 1'b1, osc);
        smp(1'b1, 16'h40F0);
        chk("log", 8'h40, log_data);
        bchk("hum", 1'b1, log_hum & log_wr);
        chk("flags", 8'h04, {4'h0, flags});
        step();
        bchk("wr2", 1'b0, log_wr);
        i_host.wr(10'h213, 8'h0A);
        rchk(10'h213, 8'hC2);
        i_host.wr(10'h211, 8'h00);
        rchk(10'h211, 8'hFF);
        fire(5'h08);
        i_host.wr(10'h213, 8'h0A);
        fire(5'h10);
        smp(1'b1, 16'hB5C3);
        chk("log", 8'hB5, log_data);
        chk("flags", 8'h0C, {4'h0, flags});
        step();
        bchk("wr2", 1'b1, log_wr);
        chk("low", 8'hC0, log_data & 8'hF0);
        step();
        bchk("wr3", 1'b0, log_wr);
        smp(1'b1, 16'h8000);
        chk("flags", 8'h0C, {4'h0, flags});
        rchk(10'h20F, 8'h80);
        fire(5'h02);
        rchk(10'h214, 8'h70);
        fire(5'h08);
    endtask
    // start on temperature alarm, halt at full, wrap
    task automatic t_alarm;
        i_host.wr(10'h210, 8'h02);
        i_host.wr(10'h213, 8'h22);
        fire(5'h10);
        bchk("wait", 1'b0, waiting);
        fire(5'h08);
        i_host.wr(10'h213, 8'h21);
        fire(5'h10);
        bchk("wait", 1'b1, waiting & conv_t);
        fire(5'h01);
        bchk("req", 1'b1, conv_req);
        smp(1'b0, 16'h5400);
        bchk("wr", 1'b0, log_wr);
        step();
        smp(1'b0, 16'h85FF);
        chk("log", 8'h85, log_data);
        bchk("inc", 1'b0, s_inc | waiting | ~log_wr);
        chk("flags", 8'h02, {4'h0, flags});
        step();
        smp(1'b0, 16'h1700);
        bchk("inc", 1'b1, s_inc & log_wr);
        chk("flags", 8'h02, {4'h0, flags});
        @(posedge clk) full <= 1'b1;
        step();
        step();
        bchk("halt", 1'b1, halted & active & osc);
        fire(5'h01);
        bchk("req", 1'b0, conv_req);
        fire(5'h08);
        i_host.wr(10'h213, 8'h15);
        fire(5'h10);
        step();
        bchk("halt", 1'b0, halted);
        smp(1'b0, 16'h5460);
        chk("log", 8'h54, log_data);
        bchk("inc", 1'b1, s_inc & log_wr);
        step();
        chk("low", 8'h60, log_data & {8{log_wr}});
        fire(5'h08);
        @(posedge clk) full <= 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // reset, then the scenarios
    initial begin
        {rstn, start, stop, fconv, clr, tick, tval, hval, full} = 9'h000;
        tres = 16'h0000;
        hres = 16'h0000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_hum();
        t_alarm();
        summarize();
    end
    // watchdog
    initial begin
        #(25 * 20000);
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
